// ==== pkg/batch_setpoint_pkg.sv ====
package batch_setpoint_pkg;

  // time base for every value-driven timer: tenths of a second
  localparam int CLK_PERIOD_NS = 20;
  localparam int TENTH_SEC_NS = 100_000_000;
  localparam int TENTH_CYCLES_DFLT = (TENTH_SEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_TIMER_CFG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CONC_CFG = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IND_CFG = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_DIN_MASK = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_MEAN_TARGET = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_MEAN_SAMPLES = 8'h24;
  // step table window: 0x40 + 4 * step
  localparam int STEP_WIN_LSB = 6;
  localparam logic [1:0] STEP_WIN_SEL = 2'h1;
  localparam int REG_IDX_LSB = 2;

  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;

  // step word and window word fields
  localparam int KIND_LSB = 0;
  localparam int KIND_W = 4;
  localparam int SEL_LSB = 4;
  localparam int SEL_W = 5;
  localparam int LINE_W = 4;
  localparam int VAL_LSB = 16;
  localparam int VAL_W = 16;
  localparam int WIN_START_LSB = 0;
  localparam int WIN_END_LSB = 4;
  localparam int WIN_SEL_LSB = 8;

  localparam int IND_ZERO_LSB = 0;
  localparam int IND_MOTION_LSB = 8;
  localparam int IND_RANGE_LSB = 16;
  localparam int IND_BATCH_LSB = 24;

  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_TOUT_BIT = 1;
  localparam int STAT_CONC_BIT = 2;
  localparam int STAT_MEAN_BIT = 3;
  localparam int STAT_JOG_BIT = 4;
  localparam int STAT_STEP_LSB = 8;
  localparam int STAT_RUNS_LSB = 16;

  localparam int INT_DONE_BIT = 0;
  localparam int INT_TIMER_BIT = 1;
  localparam int INT_JOG_BIT = 2;
  localparam int INT_W = 3;

  localparam int MEAN_LOG2_W = 4;
  localparam int SMP_W = 16;

  localparam logic [KIND_W-1:0] KIND_OFF = 4'h0;
  localparam logic [KIND_W-1:0] KIND_WEIGHT = 4'h1;
  localparam logic [KIND_W-1:0] KIND_STANDSTILL_WAIT_STEP = 4'h2;
  localparam logic [KIND_W-1:0] KIND_COUNTER = 4'h3;
  localparam logic [KIND_W-1:0] KIND_AUTOJOG = 4'h4;
  localparam logic [KIND_W-1:0] KIND_INPUT_MASK_SETPOINT = 4'h5;
  localparam logic [KIND_W-1:0] KIND_AVERAGED_WEIGHT_SETPOINT = 4'h6;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_JOG} seq_state_e;

endpackage

// ==== hdl/batch_setpoint_engine.sv ====
module batch_setpoint_engine
  import batch_setpoint_pkg::*;
#(
  parameter int NUM_STEPS = 16,
  parameter int NUM_OUT = 16,
  parameter int NUM_DIN = 8,
  parameter int WGT_W = 24,
  parameter int TENTH_CYCLES = TENTH_CYCLES_DFLT
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  input wire logic standstill,
  input wire logic zero_center,
  input wire logic in_range,
  input wire logic [NUM_STEPS-1:0] weight_sat,
  input wire logic [NUM_DIN-1:0] din,
  input wire logic sample_valid,
  input wire logic [WGT_W-1:0] raw_weight,
  output logic [NUM_OUT-1:0] dout,
  output logic irq
);

  // step index and line fields are four bits wide, so at most 16 of each
  localparam int STEP_W = $clog2(NUM_STEPS);
  localparam int PRE_W = $clog2(TENTH_CYCLES + 1);
  localparam int ACC_W = WGT_W + SMP_W;

  typedef struct packed {
    seq_state_e seq;
    logic [STEP_W-1:0] step;
    logic entry;
    logic [VAL_W-1:0] runs_left;
    logic runs_loaded;
    logic [VAL_W-1:0] jog_cnt;
    logic [PRE_W-1:0] pre_cnt;
    logic tmr_run;
    logic [VAL_W-1:0] tmr_cnt;
    logic tmr_out;
    logic conc_on;
    logic [VAL_W-1:0] conc_cnt;
    logic ss_m;
    logic ss_q;
    logic zc_m;
    logic zc_q;
    logic rg_m;
    logic rg_q;
    logic [NUM_STEPS-1:0] ws_m;
    logic [NUM_STEPS-1:0] ws_q;
    logic [NUM_DIN-1:0] din_m;
    logic [NUM_DIN-1:0] din_q;
    logic [ACC_W-1:0] acc;
    logic [SMP_W-1:0] smp_cnt;
    logic mean_sat;
    logic [NUM_STEPS-1:0][DATA_W-1:0] step_cfg;
    logic [DATA_W-1:0] tmr_cfg;
    logic [DATA_W-1:0] conc_cfg;
    logic [DATA_W-1:0] ind_cfg;
    logic [NUM_DIN-1:0] din_mask;
    logic [WGT_W-1:0] mean_target;
    logic [MEAN_LOG2_W-1:0] mean_log2;
    logic [INT_W-1:0] int_stat;
    logic [INT_W-1:0] int_mask;
    logic [NUM_OUT-1:0] dout;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } eng_s;

  localparam eng_s ENG_RESET = '0;

  eng_s eng_r;
  eng_s eng_nxt;

  function automatic logic sel_hit(input logic [SEL_W-1:0] sel, input logic [LINE_W-1:0] line);
    sel_hit = sel[SEL_W-1] && (sel[LINE_W-1:0] == line);
  endfunction

  logic [DATA_W-1:0] cur_cfg;
  logic [KIND_W-1:0] cur_kind;
  logic [VAL_W-1:0] cur_val;
  logic [SEL_W-1:0] cur_sel;
  logic [STEP_W-1:0] prev_idx;
  logic [KIND_W-1:0] prev_kind;
  logic [SEL_W-1:0] prev_sel;
  logic prev_is_wgt;
  logic prev_found;
  logic [NUM_STEPS-1:0] wgt_kind;
  logic prev_sat;
  logic running;
  logic tick;
  logic din_ok;
  logic step_on;
  logic jog_on;
  logic zero_center_indicator;
  logic motion_indicator;
  logic capacity_range_indicator;
  logic batch_active_indicator;
  logic [STEP_W-1:0] t_start;
  logic [STEP_W-1:0] t_end;
  logic [VAL_W-1:0] t_val;
  logic [STEP_W-1:0] c_start;
  logic [STEP_W-1:0] c_end;
  logic [VAL_W-1:0] c_val;
  logic in_step_win;
  logic [STEP_W-1:0] widx;
  logic start_req;
  logic abort_req;
  logic [INT_W-1:0] int_clr;
  logic [DATA_W-1:0] status_word;
  logic [SMP_W-1:0] smp_last;
  logic [NUM_OUT-1:0] drv;
  logic adv;
  logic [INT_W-1:0] ev;
  logic signed [ACC_W-1:0] sum;
  logic signed [ACC_W-1:0] mean_full;

  assign cur_cfg = eng_r.step_cfg[eng_r.step];
  assign cur_kind = cur_cfg[KIND_LSB +: KIND_W];
  assign cur_val = cur_cfg[VAL_LSB +: VAL_W];
  assign cur_sel = cur_cfg[SEL_LSB +: SEL_W];
  // autojog corrects the nearest earlier weight-type step, which may sit behind a wait step
  for (genvar j = 0; j < NUM_STEPS; j++)
  begin : g_wgt
    assign wgt_kind[j] = (eng_r.step_cfg[j][KIND_LSB +: KIND_W] == KIND_WEIGHT) ||
                         (eng_r.step_cfg[j][KIND_LSB +: KIND_W] == KIND_AVERAGED_WEIGHT_SETPOINT);
  end

  always_comb
  begin
    prev_idx = '0;
    prev_found = 1'b0;
    for (int j = 0; j < NUM_STEPS; j++)
    begin
      if (wgt_kind[j] && (STEP_W'(j) < eng_r.step))
      begin
        prev_idx = STEP_W'(j);
        prev_found = 1'b1;
      end
    end
  end

  assign prev_kind = eng_r.step_cfg[prev_idx][KIND_LSB +: KIND_W];
  assign prev_sel = eng_r.step_cfg[prev_idx][SEL_LSB +: SEL_W];
  // with no weight-type step before it, an autojog has nothing to correct
  assign prev_is_wgt = prev_found;
  assign prev_sat = (prev_kind == KIND_AVERAGED_WEIGHT_SETPOINT) ? eng_r.mean_sat
                                                                  : eng_r.ws_q[prev_idx];
  assign running = eng_r.seq != ST_IDLE;
  // one free-running tenth prescaler: windows start off-phase by under one tenth
  assign tick = eng_r.pre_cnt == PRE_W'(TENTH_CYCLES - 1);
  assign din_ok = (eng_r.din_q & eng_r.din_mask) == '0;
  assign jog_on = eng_r.seq == ST_JOG;

  always_comb
  begin
    step_on = 1'b0;
    if (running)
    begin
      case (cur_kind)
        KIND_WEIGHT: step_on = !eng_r.ws_q[eng_r.step];
        KIND_AVERAGED_WEIGHT_SETPOINT: step_on = !eng_r.mean_sat;
        KIND_INPUT_MASK_SETPOINT: step_on = din_ok;
        KIND_AUTOJOG: step_on = 1'b1;
        default: step_on = 1'b0;
      endcase
    end
  end

  assign zero_center_indicator = eng_r.zc_q;
  assign motion_indicator = !eng_r.ss_q;
  assign capacity_range_indicator = eng_r.rg_q;
  assign batch_active_indicator = running;

  assign t_start = eng_r.tmr_cfg[WIN_START_LSB +: STEP_W];
  assign t_end = eng_r.tmr_cfg[WIN_END_LSB +: STEP_W];
  assign t_val = eng_r.tmr_cfg[VAL_LSB +: VAL_W];
  assign c_start = eng_r.conc_cfg[WIN_START_LSB +: STEP_W];
  assign c_end = eng_r.conc_cfg[WIN_END_LSB +: STEP_W];
  assign c_val = eng_r.conc_cfg[VAL_LSB +: VAL_W];

  assign in_step_win = addr[ADDR_W-1:STEP_WIN_LSB] == STEP_WIN_SEL;
  assign widx = addr[REG_IDX_LSB +: STEP_W];
  assign start_req = wr && (addr == OFS_CTRL) && wdata[CTRL_START_BIT];
  assign abort_req = wr && (addr == OFS_CTRL) && wdata[CTRL_ABORT_BIT];
  assign int_clr = (wr && (addr == OFS_INT_STAT)) ? wdata[INT_W-1:0] : '0;
  assign smp_last = (SMP_W'(1) << eng_r.mean_log2) - SMP_W'(1);

  assign status_word = (DATA_W'(eng_r.runs_left) << STAT_RUNS_LSB) |
                       (DATA_W'(eng_r.step) << STAT_STEP_LSB) |
                       (DATA_W'(jog_on) << STAT_JOG_BIT) |
                       (DATA_W'(eng_r.mean_sat) << STAT_MEAN_BIT) |
                       (DATA_W'(eng_r.conc_on) << STAT_CONC_BIT) |
                       (DATA_W'(eng_r.tmr_out) << STAT_TOUT_BIT) |
                       (DATA_W'(running) << STAT_RUN_BIT);

  // any number of sources may claim one line; they are or-ed
  for (genvar i = 0; i < NUM_OUT; i++)
  begin : g_line
    assign drv[i] =
      (step_on && sel_hit(cur_sel, LINE_W'(i))) |
      (jog_on && sel_hit(prev_sel, LINE_W'(i))) |
      (zero_center_indicator && sel_hit(eng_r.ind_cfg[IND_ZERO_LSB +: SEL_W], LINE_W'(i))) |
      (motion_indicator && sel_hit(eng_r.ind_cfg[IND_MOTION_LSB +: SEL_W], LINE_W'(i))) |
      (capacity_range_indicator && sel_hit(eng_r.ind_cfg[IND_RANGE_LSB +: SEL_W], LINE_W'(i))) |
      (batch_active_indicator && sel_hit(eng_r.ind_cfg[IND_BATCH_LSB +: SEL_W], LINE_W'(i))) |
      (eng_r.tmr_out && sel_hit(eng_r.tmr_cfg[WIN_SEL_LSB +: SEL_W], LINE_W'(i))) |
      (eng_r.conc_on && sel_hit(eng_r.conc_cfg[WIN_SEL_LSB +: SEL_W], LINE_W'(i)));
  end

  always_comb
  begin
    adv = 1'b0;
    ev = '0;
    sum = '0;
    mean_full = '0;
    eng_nxt = eng_r;
    eng_nxt.entry = 1'b0;
    eng_nxt.pre_cnt = tick ? '0 : PRE_W'(eng_r.pre_cnt + 1'b1);

    // pin status passes two flops before anything looks at it
    eng_nxt.ss_m = standstill;
    eng_nxt.ss_q = eng_r.ss_m;
    eng_nxt.zc_m = zero_center;
    eng_nxt.zc_q = eng_r.zc_m;
    eng_nxt.rg_m = in_range;
    eng_nxt.rg_q = eng_r.rg_m;
    eng_nxt.ws_m = weight_sat;
    eng_nxt.ws_q = eng_r.ws_m;
    eng_nxt.din_m = din;
    eng_nxt.din_q = eng_r.din_m;

    case (eng_r.seq)
      ST_IDLE:
      begin
        if (start_req)
        begin
          eng_nxt.seq = ST_RUN;
          eng_nxt.step = '0;
          eng_nxt.entry = 1'b1;
          eng_nxt.runs_left = VAL_W'(1);
          eng_nxt.runs_loaded = 1'b0;
          eng_nxt.tmr_out = 1'b0;
        end
      end
      ST_RUN:
      begin
        case (cur_kind)
          KIND_WEIGHT: adv = eng_r.ws_q[eng_r.step];
          // the stale mean is cleared on entry, so a fresh one is awaited
          KIND_AVERAGED_WEIGHT_SETPOINT: adv = eng_r.mean_sat && !eng_r.entry;
          KIND_STANDSTILL_WAIT_STEP: adv = eng_r.ss_q;
          KIND_COUNTER:
          begin
            // loaded once per batch; later passes over the step leave it alone
            if (!eng_r.runs_loaded)
            begin
              eng_nxt.runs_left = (cur_val == '0) ? VAL_W'(1) : cur_val;
              eng_nxt.runs_loaded = 1'b1;
            end
            adv = 1'b1;
          end
          KIND_AUTOJOG:
          begin
            if (!prev_is_wgt)
              adv = 1'b1;
            else if (eng_r.ss_q)
            begin
              if (prev_sat)
                adv = 1'b1;
              else
              begin
                eng_nxt.seq = ST_JOG;
                eng_nxt.jog_cnt = '0;
                ev[INT_JOG_BIT] = 1'b1;
              end
            end
          end
          KIND_INPUT_MASK_SETPOINT: adv = din_ok;
          default: adv = 1'b1;
        endcase
      end
      ST_JOG:
      begin
        // back to the check, which waits for standstill again
        if (eng_r.jog_cnt >= cur_val)
          eng_nxt.seq = ST_RUN;
        else if (tick)
          eng_nxt.jog_cnt = VAL_W'(eng_r.jog_cnt + 1'b1);
      end
      default: eng_nxt.seq = ST_IDLE;
    endcase

    if (adv)
    begin
      eng_nxt.entry = 1'b1;
      if (eng_r.step == STEP_W'(NUM_STEPS - 1))
      begin
        if (eng_r.runs_left > VAL_W'(1))
        begin
          eng_nxt.runs_left = VAL_W'(eng_r.runs_left - 1'b1);
          eng_nxt.step = '0;
        end
        else
        begin
          eng_nxt.seq = ST_IDLE;
          eng_nxt.entry = 1'b0;
          ev[INT_DONE_BIT] = 1'b1;
        end
      end
      else
        eng_nxt.step = STEP_W'(eng_r.step + 1'b1);
    end

    if (abort_req && running)
    begin
      eng_nxt.seq = ST_IDLE;
      eng_nxt.entry = 1'b0;
    end

    // raw samples only; rounding for display never reaches this path
    if (sample_valid)
    begin
      sum = $signed(eng_r.acc) + ACC_W'($signed(raw_weight));
      if (eng_r.smp_cnt >= smp_last)
      begin
        mean_full = sum >>> eng_r.mean_log2;
        eng_nxt.mean_sat = mean_full >= ACC_W'($signed(eng_r.mean_target));
        eng_nxt.acc = '0;
        eng_nxt.smp_cnt = '0;
      end
      else
      begin
        eng_nxt.acc = sum;
        eng_nxt.smp_cnt = SMP_W'(eng_r.smp_cnt + 1'b1);
      end
    end
    if (eng_r.entry && (cur_kind == KIND_AVERAGED_WEIGHT_SETPOINT))
    begin
      eng_nxt.mean_sat = 1'b0;
      eng_nxt.acc = '0;
      eng_nxt.smp_cnt = '0;
    end

    if (!running)
      eng_nxt.tmr_run = 1'b0;
    else if (eng_r.entry && (eng_r.step == t_start))
    begin
      eng_nxt.tmr_run = 1'b1;
      eng_nxt.tmr_cnt = '0;
      eng_nxt.tmr_out = 1'b0;
    end
    else if (eng_r.tmr_run)
    begin
      if (eng_r.entry && (eng_r.step == t_end))
        eng_nxt.tmr_run = 1'b0;
      else if (eng_r.tmr_cnt >= t_val)
      begin
        eng_nxt.tmr_out = 1'b1;
        eng_nxt.tmr_run = 1'b0;
        ev[INT_TIMER_BIT] = 1'b1;
      end
      else if (tick)
        eng_nxt.tmr_cnt = VAL_W'(eng_r.tmr_cnt + 1'b1);
    end

    if (!running)
      eng_nxt.conc_on = 1'b0;
    else if (eng_r.entry && (eng_r.step == c_start))
    begin
      eng_nxt.conc_on = 1'b1;
      eng_nxt.conc_cnt = '0;
    end
    else if (eng_r.conc_on)
    begin
      if (c_val == '0)
      begin
        if (eng_r.entry && (eng_r.step == c_end))
          eng_nxt.conc_on = 1'b0;
      end
      else if (eng_r.conc_cnt >= c_val)
        eng_nxt.conc_on = 1'b0;
      else if (tick)
        eng_nxt.conc_cnt = VAL_W'(eng_r.conc_cnt + 1'b1);
    end

    if (wr)
    begin
      case (addr)
        OFS_INT_MASK: eng_nxt.int_mask = wdata[INT_W-1:0];
        OFS_TIMER_CFG: eng_nxt.tmr_cfg = wdata;
        OFS_CONC_CFG: eng_nxt.conc_cfg = wdata;
        OFS_IND_CFG: eng_nxt.ind_cfg = wdata;
        OFS_DIN_MASK: eng_nxt.din_mask = wdata[NUM_DIN-1:0];
        OFS_MEAN_TARGET: eng_nxt.mean_target = wdata[WGT_W-1:0];
        OFS_MEAN_SAMPLES: eng_nxt.mean_log2 = wdata[MEAN_LOG2_W-1:0];
        default:
        begin
          if (in_step_win)
            eng_nxt.step_cfg[widx] = wdata;
        end
      endcase
    end

    // a new event wins over a clear written in the same cycle
    eng_nxt.int_stat = (eng_r.int_stat & ~int_clr) | ev;
    eng_nxt.irq = |(eng_nxt.int_stat & eng_nxt.int_mask);
    eng_nxt.dout = drv;

    eng_nxt.rdata = '0;
    if (rd)
    begin
      case (addr)
        OFS_STATUS: eng_nxt.rdata = status_word;
        OFS_INT_STAT: eng_nxt.rdata = DATA_W'(eng_r.int_stat);
        OFS_INT_MASK: eng_nxt.rdata = DATA_W'(eng_r.int_mask);
        OFS_TIMER_CFG: eng_nxt.rdata = eng_r.tmr_cfg;
        OFS_CONC_CFG: eng_nxt.rdata = eng_r.conc_cfg;
        OFS_IND_CFG: eng_nxt.rdata = eng_r.ind_cfg;
        OFS_DIN_MASK: eng_nxt.rdata = DATA_W'(eng_r.din_mask);
        OFS_MEAN_TARGET: eng_nxt.rdata = DATA_W'(eng_r.mean_target);
        OFS_MEAN_SAMPLES: eng_nxt.rdata = DATA_W'(eng_r.mean_log2);
        default:
        begin
          if (in_step_win)
            eng_nxt.rdata = eng_r.step_cfg[widx];
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      eng_r <= ENG_RESET;
    else
      eng_r <= eng_nxt;
  end

  assign rdata = eng_r.rdata;
  assign dout = eng_r.dout;
  assign irq = eng_r.irq;

endmodule

// ==== verif/batch_setpoint_engine_assertions.sv ====
module batch_setpoint_checker
  import batch_setpoint_pkg::*;
#(
  parameter int NUM_STEPS = 16,
  parameter int NUM_OUT = 16,
  parameter int NUM_DIN = 8,
  parameter int WGT_W = 24
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic standstill,
  input wire logic zero_center,
  input wire logic in_range,
  input wire logic [NUM_STEPS-1:0] weight_sat,
  input wire logic [NUM_DIN-1:0] din,
  input wire logic sample_valid,
  input wire logic [WGT_W-1:0] raw_weight,
  input wire logic [NUM_OUT-1:0] dout,
  input wire logic irq
);
  // shadow of the indicator selects; line checks wait until it has settled through the syncs
  logic [DATA_W-1:0] ind_r;
  logic [2:0] age_r;
  logic [4:0] zs;
  logic [4:0] ms;
  logic [4:0] rs;
  logic [4:0] bs;
  assign zs = ind_r[IND_ZERO_LSB +: 5];
  assign ms = ind_r[IND_MOTION_LSB +: 5];
  assign rs = ind_r[IND_RANGE_LSB +: 5];
  assign bs = ind_r[IND_BATCH_LSB +: 5];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ind_r <= '0;
      age_r <= '0;
    end
    else if (wr && addr == OFS_IND_CFG)
    begin
      ind_r <= wdata;
      age_r <= '0;
    end
    else if (age_r != 3'h7)
      age_r <= age_r + 3'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_ZERO_LINE: assert property (
    age_r == 3'h7 && zs[4] && $past(zero_center, 3) |-> dout[zs[3:0]])
    else $error("zero center line not driven");
  AST_MOTION_LINE: assert property (
    age_r == 3'h7 && ms[4] && !$past(standstill, 3) |-> dout[ms[3:0]])
    else $error("motion line not driven");
  AST_RANGE_LINE: assert property (
    age_r == 3'h7 && rs[4] && $past(in_range, 3) |-> dout[rs[3:0]])
    else $error("range line not driven");
  AST_BATCH_LINE: assert property (
    age_r == 3'h7 && bs[4] && wr && addr == OFS_CTRL && wdata[CTRL_START_BIT]
      && !wdata[CTRL_ABORT_BIT] |-> ##2 dout[bs[3:0]])
    else $error("batch active line not driven after start");
  AST_RDATA_QUIET: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data outside the answer cycle");
  AST_RESET_QUIET: assert property (!$past(resetn) |-> dout == '0 && !irq)
    else $error("outputs active right after reset");
  AST_IRQ_STICKY: assert property (
    irq && !(wr && (addr == OFS_INT_STAT || addr == OFS_INT_MASK)) |=> irq)
    else $error("interrupt dropped without a clear or mask write");
  AST_IRQ_MASK_OFF: assert property (
    wr && addr == OFS_INT_MASK && wdata[INT_W-1:0] == '0 |=> !irq)
    else $error("interrupt high with all sources masked");
endmodule

bind batch_setpoint_engine batch_setpoint_checker #(.NUM_STEPS(NUM_STEPS), .NUM_OUT(NUM_OUT),
  .NUM_DIN(NUM_DIN), .WGT_W(WGT_W)) batch_setpoint_checker_inst (.clk(clk), .resetn(resetn),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .standstill(standstill),
  .zero_center(zero_center), .in_range(in_range), .weight_sat(weight_sat), .din(din),
  .sample_valid(sample_valid), .raw_weight(raw_weight), .dout(dout), .irq(irq));

// ==== verif/scale_front_model.sv ====
module scale_front_model
  import batch_setpoint_pkg::*;
#(
  parameter int FEED_NEED = 30
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] dout,
  input wire logic ss_req,
  input wire logic zc_req,
  input wire logic rng_req,
  input wire logic ws_req,
  input wire logic [7:0] din_req,
  input wire logic [23:0] wavg,
  output logic standstill,
  output logic zero_center,
  output logic in_range,
  output logic [15:0] weight_sat,
  output logic [7:0] din,
  output logic sample_valid,
  output logic [23:0] raw_weight
);
  // feed time accumulated on line 4 while line 5 shows a correction
  logic [5:0] feed;
  logic [1:0] ph;
  logic odd;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      {standstill, zero_center, in_range, sample_valid, odd} <= '0;
      weight_sat <= '0;
      din <= '0;
      raw_weight <= '0;
      feed <= '0;
      ph <= '0;
    end
    else
    begin
      standstill <= ss_req;
      zero_center <= zc_req;
      in_range <= rng_req;
      din <= din_req;
      if (dout[4] && dout[5] && feed != 6'h3F)
        feed <= feed + 6'h01;
      // one jog pulse is never enough, so the correction must repeat
      weight_sat <= {14'h0, ws_req || feed >= 6'(FEED_NEED), 1'b0};
      ph <= ph + 2'h1;
      sample_valid <= ph == 2'h0;
      odd <= odd ^ (ph == 2'h0);
      // raw words alternate by one count; between samples the word is not valid
      raw_weight <= (ph == 2'h0) ? wavg + {23'h0, odd} : ~raw_weight;
    end
  end
endmodule

// ==== verif/tb_batch_setpoint_engine.sv ====
module tb_batch_setpoint_engine
  import batch_setpoint_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, resetn, wr, rd, standstill, zero_center, in_range, sample_valid, irq;
  logic ss_req, zc_req, rng_req, ws_req;
  logic [7:0] addr, din, din_req;
  logic [31:0] wdata, rdata;
  logic [15:0] weight_sat, dout;
  logic [23:0] raw_weight, wavg;
  int n_errors, comparisons, cyc, n;
  localparam logic [31:0] STEPS [6] = '{32'h0002_0003, 32'h0000_0141, 32'h0000_0002,
    32'h0002_0154, 32'h0000_0165, 32'h0000_0176};

  batch_setpoint_engine #(.TENTH_CYCLES(8)) batch_setpoint_engine_inst (.clk(clk),
    .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .standstill(standstill), .zero_center(zero_center), .in_range(in_range),
    .weight_sat(weight_sat), .din(din), .sample_valid(sample_valid),
    .raw_weight(raw_weight), .dout(dout), .irq(irq));
  scale_front_model scale_front_model_inst (.clk(clk), .resetn(resetn), .dout(dout),
    .ss_req(ss_req), .zc_req(zc_req), .rng_req(rng_req), .ws_req(ws_req),
    .din_req(din_req), .wavg(wavg), .standstill(standstill), .zero_center(zero_center),
    .in_range(in_range), .weight_sat(weight_sat), .din(din), .sample_valid(sample_valid),
    .raw_weight(raw_weight));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      $display("ERROR %0t run did not finish", $time);
      results();
    end
  end

  task automatic results();
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data stand only in the cycle after the strobe
    #1 v = rdata;
  endtask

  // polls up to tries reads until the masked word matches, then compares it
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v,
                          input int tries);
    logic [31:0] x;
    x = ~v;
    for (int i = 0; i < tries && (x & m) !== v; i++)
      rd_reg(a, x);
    chk(x & m, v);
  endtask

  task automatic set_front(input logic ss, input logic zc, input logic rng);
    @(posedge clk);
    ss_req <= ss;
    zc_req <= zc;
    rng_req <= rng;
  endtask

  initial
  begin
    {resetn, wr, rd, ss_req, zc_req, rng_req, ws_req} = '0;
    {addr, din_req, wdata, wavg} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    wait_reg(OFS_STATUS, '1, 32'h0, 1);
    wait_reg(OFS_INT_MASK, '1, 32'h0, 1);
    wr_reg(8'h30, '1);
    wait_reg(8'h30, '1, 32'h0, 1);
    wr_reg(OFS_IND_CFG, 32'h1312_1110);
    set_front(1'b0, 1'b1, 1'b1);
    #121 chk(dout[3:0], 4'h7);
    set_front(1'b1, 1'b0, 1'b0);
    #121 chk(dout[3:0], 4'h0);
    wr_reg(OFS_INT_MASK, 32'h7);
    foreach (STEPS[i]) wr_reg(8'h40 + 8'(4 * i), STEPS[i]);
    wr_reg(OFS_DIN_MASK, 32'h3);
    wr_reg(OFS_MEAN_TARGET, 32'h64);
    wr_reg(OFS_MEAN_SAMPLES, 32'h2);
    wr_reg(OFS_TIMER_CFG, 32'h0001_1851);
    wr_reg(OFS_CONC_CFG, 32'h0000_1931);
    set_front(1'b0, 1'b0, 1'b0);
    ws_req <= 1'b1;
    din_req <= 8'h01;
    wr_reg(OFS_CTRL, 32'h1);
    wait_reg(OFS_STATUS, 32'hF00, 32'h200, 300);
    #600;
    wait_reg(OFS_STATUS, '1, 32'h0002_0207, 1);
    chk({dout[9:8], dout[3], irq}, 4'hF);
    wait_reg(OFS_INT_STAT, '1, 32'h2, 1);
    wr_reg(OFS_INT_STAT, 32'h2);
    @(posedge clk);
    #1 chk(irq, 1'b0);
    // weight drops below target before standstill, so the autojog must correct it
    ws_req <= 1'b0;
    #100;
    set_front(1'b1, 1'b0, 1'b0);
    #1;
    for (n = 0; n < 400 && dout[4] !== 1'b1; n++) #20;
    chk(dout[5], 1'b1);
    for (n = 0; n < 40 && dout[4] === 1'b1; n++) #20;
    chk(n >= 8 && n <= 24, 1'b1);
    wait_reg(OFS_STATUS, 32'hF00, 32'h300, 1);
    wait_reg(OFS_STATUS, 32'hF00, 32'h400, 300);
    wait_reg(OFS_INT_STAT, 32'h4, 32'h4, 1);
    #200;
    chk({dout[9], dout[6]}, 2'b00);
    wait_reg(OFS_STATUS, 32'hF00, 32'h400, 1);
    @(posedge clk);
    din_req <= 8'h04;
    wavg <= 24'h000063;
    wait_reg(OFS_STATUS, 32'hF00, 32'h500, 300);
    #1200;
    wait_reg(OFS_STATUS, 32'hF00, 32'h500, 1);
    chk(dout[7], 1'b1);
    @(posedge clk);
    wavg <= 24'h000064;
    wait_reg(OFS_STATUS, 32'hFFFF_0F00, 32'h0001_0500, 300);
    wait_reg(OFS_INT_STAT, 32'h1, 32'h1, 300);
    #100;
    chk({irq, dout[3]}, 2'b10);
    results();
  end
endmodule
